// *** sbma_defs.vh ***
// Constants for the system bus mastership arbiter.
// Assumes one 100 MHz interface clock; handshakes active low.
// How it works
// - Request asserted; processor releases by deasserting master
// - Master state returns when external request completes
// - Processor releases bus itself after read issue
// - After uncompelled release, resume after next request
// - Each valid strobe cycle marks new word
// - One idle cycle between outgoing and incoming driver
// - Command accepted only if accept held two cycles
// - Accept dropped in command cycle kills command
// - Agent waits for release, keeps bus while requesting
// - Grant after at most one further processor request
// - Pending read holds slave until end-of-data response, unless an agent request rises and drops first
// - Agent keeps bus after end-of-data only by requesting
// - Processor drives bus two cycles after request drops
// - Processor accepts agent traffic, never stalls it
// - Slave processor needing bus waits for request drop
// - Either reset makes processor bus master
// - Exactly one master; tri-state only at handover
// - Outputs registered, inputs captured on rising edge
// - Command top bit: 0 address, 1 data
`ifndef SBMA_DEFS_VH
`define SBMA_DEFS_VH
`define SBMA_AD_W 32
`define SBMA_CMD_W 5
`define SBMA_CMD_DATA_BIT 4
`define SBMA_EOD_BIT 3
`define SBMA_READ_CODE 4'h0
`define SBMA_WRITE_CODE 4'h8
`endif

// *** sbma_arbiter.v ***
// Bus mastership arbiter for the processor end of the shared system bus.
// Assumes the external agent keeps its side of the handshake; bus pins
// are split into in/out/enable and resolved outside.
`include "sbma_defs.vh"

module sbma_arbiter #(
   parameter AD_W = `SBMA_AD_W,
   parameter CMD_W = `SBMA_CMD_W
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire reset_i,
   input wire warm_reset_n_i,
   input wire cold_reset_n_i,
   // Processor core request side
   input wire req_valid_i,
   input wire [AD_W-1:0] req_addr_i,
   input wire [CMD_W-2:0] req_cmd_i,
   input wire req_is_read_i,
   input wire wdata_valid_i,
   input wire [AD_W-1:0] wdata_i,
   input wire wdata_last_i,
   output reg req_done_o,
   output reg req_killed_o,
   // Received words from the agent
   output reg rx_valid_o,
   output reg [AD_W-1:0] rx_ad_o,
   output reg [CMD_W-1:0] rx_cmd_o,
   output reg read_pending_o,
   // Handshake pins, active low
   input wire ext_bus_request_n_i,
   input wire ext_valid_n_i,
   input wire ext_accept_n_i,
   output reg proc_master_n_o,
   output reg proc_valid_n_o,
   // Shared buses
   input wire [AD_W-1:0] sys_addr_data_bus_i,
   output reg [AD_W-1:0] sys_addr_data_bus_o,
   output reg sys_addr_data_bus_oe_o,
   input wire [CMD_W-1:0] sys_command_bus_i,
   output reg [CMD_W-1:0] sys_command_bus_o,
   output reg sys_command_bus_oe_o
);

   // --------------------------------------------------------------
   // States
   // --------------------------------------------------------------
   localparam [4:0] S_MASTER = 5'h01;
   localparam [4:0] S_WDATA = 5'h02;
   localparam [4:0] S_REL = 5'h04;
   localparam [4:0] S_SLAVE = 5'h08;
   localparam [4:0] S_RET = 5'h10;

   // --------------------------------------------------------------
   // Input capture
   // --------------------------------------------------------------
   // Reset pins are asynchronous: three flops, a change counts once stages 2 and 3 agree.
   // Handshakes and buses come from logic on this clock: one capture flop each, so a
   // single-cycle valid strobe is never filtered away and stays aligned with its word.
   reg [2:0] wrn_s_q, crn_s_q;
   reg ext_bus_request_n_n_q, eval_n_q, eok_n_q, eok_prev_n_q, rst_n_q;
   reg [AD_W-1:0] ad_in_q;
   reg [CMD_W-1:0] cmd_in_q;

   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wrn_s_q <= 3'h7;
         crn_s_q <= 3'h7;
         ext_bus_request_n_n_q <= 1'h1;
         eval_n_q <= 1'h1;
         eok_n_q <= 1'h1;
         eok_prev_n_q <= 1'h1;
         rst_n_q <= 1'h1;
         ad_in_q <= {AD_W{1'b0}};
         cmd_in_q <= {CMD_W{1'b0}};
      end else begin
         wrn_s_q <= {wrn_s_q[1:0], warm_reset_n_i};
         crn_s_q <= {crn_s_q[1:0], cold_reset_n_i};
         ext_bus_request_n_n_q <= ext_bus_request_n_i;
         eval_n_q <= ext_valid_n_i;
         eok_n_q <= ext_accept_n_i;
         eok_prev_n_q <= eok_n_q;
         if (wrn_s_q[1] == wrn_s_q[2] && crn_s_q[1] == crn_s_q[2])
            rst_n_q <= wrn_s_q[2] & crn_s_q[2];
         ad_in_q <= sys_addr_data_bus_i;
         cmd_in_q <= sys_command_bus_i;
      end
   end

   wire ext_bus_request_n = ~ext_bus_request_n_n_q;
   wire eval = ~eval_n_q;
   // Accept must be seen in the cycle before and the command cycle
   wire accept_ok = ~eok_n_q & ~eok_prev_n_q;
   wire eod_in = eval & cmd_in_q[`SBMA_CMD_DATA_BIT] & cmd_in_q[`SBMA_EOD_BIT];

   // --------------------------------------------------------------
   // Mastership state machine
   // --------------------------------------------------------------
   reg [4:0] state_q, state_d;
   reg by_arb_q, by_arb_d;
   reg rd_pend_q, rd_pend_d;
   reg one_req_q, one_req_d;
   reg issue_d, kill_d, done_d;

   always @* begin
      state_d = state_q;
      by_arb_d = by_arb_q;
      rd_pend_d = rd_pend_q;
      one_req_d = one_req_q;
      issue_d = 1'b0;
      kill_d = 1'b0;
      done_d = 1'b0;
      case (state_q)
         S_MASTER: begin
            // Grant when idle, once one request has gone out while the agent requests, or at once
            // if the agent holds accept off
            if (ext_bus_request_n && (one_req_q || eok_n_q || !req_valid_i)) begin
               state_d = S_REL;
               by_arb_d = 1'b1;
            end else if (req_valid_i) begin
               issue_d = 1'b1;
               if (ext_bus_request_n) one_req_d = 1'b1;
               if (accept_ok) begin
                  done_d = 1'b1;
                  if (req_is_read_i) begin
                     // Release in the cycle after issue
                     rd_pend_d = 1'b1;
                     by_arb_d = 1'b0;
                     state_d = S_REL;
                  end else begin
                     state_d = S_WDATA;
                  end
               end else begin
                  kill_d = 1'b1;
               end
            end
         end
         S_WDATA: if (wdata_valid_i && wdata_last_i) state_d = S_MASTER;
         S_REL: state_d = S_SLAVE;
         S_SLAVE: begin
            if (eod_in) rd_pend_d = 1'b0;
            if (by_arb_q) begin
               if (!ext_bus_request_n) state_d = S_RET;
            end else if (eval && cmd_in_q[`SBMA_CMD_DATA_BIT]
                         && cmd_in_q[`SBMA_EOD_BIT]) begin
               // End of the next external request; requesting agent keeps bus
               if (ext_bus_request_n) by_arb_d = 1'b1;
               else state_d = S_RET;
            end else if (ext_bus_request_n) begin
               by_arb_d = 1'b1;
            end
         end
         S_RET: begin
            state_d = S_MASTER;
            by_arb_d = 1'b0;
            one_req_d = 1'b0;
         end
         default: state_d = S_MASTER;
      endcase
   end

   // --------------------------------------------------------------
   // Registered state and pins
   // --------------------------------------------------------------
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= S_MASTER;
         by_arb_q <= 1'b0;
         rd_pend_q <= 1'b0;
         one_req_q <= 1'b0;
         proc_master_n_o <= 1'b0;
         proc_valid_n_o <= 1'b1;
         sys_addr_data_bus_o <= {AD_W{1'b0}};
         sys_addr_data_bus_oe_o <= 1'b1;
         sys_command_bus_o <= {CMD_W{1'b0}};
         sys_command_bus_oe_o <= 1'b1;
         req_done_o <= 1'b0;
         req_killed_o <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_ad_o <= {AD_W{1'b0}};
         rx_cmd_o <= {CMD_W{1'b0}};
         read_pending_o <= 1'b0;
      end else if (!rst_n_q) begin
         // Warm or cold reset pin: take mastership back at once
         state_q <= S_MASTER;
         by_arb_q <= 1'b0;
         rd_pend_q <= 1'b0;
         one_req_q <= 1'b0;
         proc_master_n_o <= 1'b0;
         proc_valid_n_o <= 1'b1;
         sys_addr_data_bus_oe_o <= 1'b1;
         sys_command_bus_oe_o <= 1'b1;
         req_done_o <= 1'b0;
         req_killed_o <= 1'b0;
         rx_valid_o <= 1'b0;
         read_pending_o <= 1'b0;
      end else begin
         state_q <= state_d;
         by_arb_q <= by_arb_d;
         rd_pend_q <= rd_pend_d;
         one_req_q <= one_req_d;
         read_pending_o <= rd_pend_d;
         req_done_o <= done_d;
         req_killed_o <= kill_d;
         // Drivers only on in master states; REL and RET are the idle cycle
         proc_master_n_o <= ~(state_d == S_MASTER || state_d == S_WDATA);
         sys_addr_data_bus_oe_o <= (state_d == S_MASTER || state_d == S_WDATA);
         sys_command_bus_oe_o <= (state_d == S_MASTER || state_d == S_WDATA);
         // Strobe the command word, then write data words
         if (issue_d) begin
            proc_valid_n_o <= 1'b0;
            sys_addr_data_bus_o <= req_addr_i;
            sys_command_bus_o <= {1'b0, req_cmd_i};
         end else if (state_q == S_WDATA && wdata_valid_i) begin
            proc_valid_n_o <= 1'b0;
            sys_addr_data_bus_o <= wdata_i;
            sys_command_bus_o <= {1'b1, wdata_last_i, 3'h0};
         end else begin
            proc_valid_n_o <= 1'b1;
         end
         // Agent words are always taken in S_SLAVE; there is no stall path
         rx_valid_o <= eval && state_q == S_SLAVE;
         rx_ad_o <= ad_in_q;
         rx_cmd_o <= cmd_in_q;
      end
   end

endmodule // sbma_arbiter

// *** sbma_checker.sv ***
// Port-level checker for the bus mastership arbiter.
// Assumes one clock domain and an active-high asynchronous reset.
module sbma_checker #(parameter CMD_W = 5) (
   input wire logic ref_clk_i, reset_i, ext_bus_request_n_i, req_is_read_i,
   input wire logic req_done_o, req_killed_o, read_pending_o, proc_master_n_o,
   input wire logic proc_valid_n_o, sys_addr_data_bus_oe_o, sys_command_bus_oe_o,
   input wire logic [CMD_W-1:0] sys_command_bus_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);
   sequence cmd_out_s;
      req_done_o || req_killed_o;
   endsequence
   sequence agent_done_s;
      $rose(ext_bus_request_n_i) && proc_master_n_o && !read_pending_o;
   endsequence
   bus_pair_a: assert property (
      sys_addr_data_bus_oe_o == sys_command_bus_oe_o) else $error("oe split");
   one_master_a: assert property (
      proc_master_n_o != sys_addr_data_bus_oe_o) else $error("master vs drive");
   cmd_strobe_a: assert property (
      cmd_out_s |-> !proc_valid_n_o && !sys_command_bus_o[CMD_W-1]) else $error("cmd cycle");
   turn_gap_a: assert property (
      $fell(sys_command_bus_oe_o) |=> !sys_command_bus_oe_o) else $error("no idle cycle");
   read_drop_a: assert property (
      req_done_o && req_is_read_i |-> ##[1:2] proc_master_n_o) else $error("no release");
   read_hold_a: assert property (
      proc_master_n_o && read_pending_o |=> proc_master_n_o) else $error("early return");
   grant_bound_a: assert property (
      $fell(ext_bus_request_n_i) && !proc_master_n_o |-> ##[1:12] proc_master_n_o)
      else $error("no grant");
   agent_return_a: assert property (
      agent_done_s |-> proc_master_n_o [*2] ##[1:8] !proc_master_n_o) else $error("no return");
endmodule // sbma_checker

bind sbma_arbiter sbma_checker #(.CMD_W(CMD_W)) chk_i (.ref_clk_i, .reset_i,
   .ext_bus_request_n_i, .req_is_read_i, .req_done_o, .req_killed_o, .read_pending_o,
   .proc_master_n_o, .proc_valid_n_o, .sys_addr_data_bus_oe_o, .sys_command_bus_oe_o,
   .sys_command_bus_o);

// *** sbma_agent_model.sv ***
// Behavioural external agent facing the arbiter.
// Assumes the bench resolves the shared buses from both enables.
module sbma_agent_model (
   input wire logic ref_clk_i, reset_i, want_bus_i, accept_i, send_eod_i, proc_master_n_i,
   output wire logic ext_bus_request_n_o, ext_accept_n_o,
   output logic ext_valid_n_o, oe_o,
   output wire logic [31:0] ad_o,
   output wire logic [4:0] cmd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] slv_q;
   logic pend_q;
   assign ext_bus_request_n_o = !want_bus_i;
   assign ext_accept_n_o = !accept_i;
   assign ad_o = 32'h1234_5678;
   assign cmd_o = 5'h18;
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         slv_q <= 2'h0;
         pend_q <= 1'b0;
         oe_o <= 1'b0;
         ext_valid_n_o <= 1'b1;
      end else begin
         // Drive only after two slave samples so the turnaround cycle stays empty
         slv_q <= !proc_master_n_i ? 2'h0 : (slv_q == 2'h2 ? 2'h2 : slv_q + 2'h1);
         oe_o <= proc_master_n_i && slv_q == 2'h2 && (want_bus_i || pend_q);
         ext_valid_n_o <= !(oe_o && pend_q);
         if (send_eod_i) pend_q <= 1'b1;
         else if (oe_o && pend_q) pend_q <= 1'b0;
      end
   end
endmodule // sbma_agent_model

// *** system_bus_mastership_arbiter_tb_top.sv ***
// Self-checking bench for the bus mastership arbiter.
// Assumes the agent model answers on its own side of the handshake.
module system_bus_mastership_arbiter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, cold_n = 1, rv = 0, rd = 0, wv = 0, want = 0, acc = 1, end_of_data_tag = 0;
   logic done, kill, m_n, pv_n, pend, rxv, d_oe, c_oe, a_oe, ext_bus_request_n_n, ev_n, ok_n, tg = 0;
   logic [31:0] d_ad, a_ad, ad, rxa;
   logic [4:0] d_cmd, a_cmd, cmd, rxc;
   int n_errors = 0, num_checks = 0;
   always #5 clk = ~clk;
   always @(posedge clk) tg <= ~tg;
   // An undriven bus flips every cycle so stale values never pass
   assign ad = d_oe ? d_ad : a_oe ? a_ad : {16{tg, ~tg}};
   assign cmd = c_oe ? d_cmd : a_oe ? a_cmd : {5{tg}};
   sbma_arbiter dut (.ref_clk_i(clk), .reset_i(rst), .warm_reset_n_i(1'b1),
      .cold_reset_n_i(cold_n), .req_valid_i(rv), .req_addr_i(32'h0000_1000),
      .req_cmd_i(rd ? 4'h0 : 4'h8), .req_is_read_i(rd), .wdata_valid_i(wv),
      .wdata_i(32'hcafe_0001), .wdata_last_i(wv), .req_done_o(done), .req_killed_o(kill),
      .rx_valid_o(rxv), .rx_ad_o(rxa), .rx_cmd_o(rxc), .read_pending_o(pend),
      .ext_bus_request_n_i(ext_bus_request_n_n), .ext_valid_n_i(ev_n), .ext_accept_n_i(ok_n),
      .proc_master_n_o(m_n), .proc_valid_n_o(pv_n), .sys_addr_data_bus_i(ad),
      .sys_addr_data_bus_o(d_ad), .sys_addr_data_bus_oe_o(d_oe), .sys_command_bus_i(cmd),
      .sys_command_bus_o(d_cmd), .sys_command_bus_oe_o(c_oe));
   sbma_agent_model agent (.ref_clk_i(clk), .reset_i(rst), .want_bus_i(want), .accept_i(acc),
      .send_eod_i(end_of_data_tag), .proc_master_n_i(m_n), .ext_bus_request_n_o(ext_bus_request_n_n),
      .ext_accept_n_o(ok_n), .ext_valid_n_o(ev_n), .oe_o(a_oe), .ad_o(a_ad), .cmd_o(a_cmd));
   task automatic chk(input logic got, input logic exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask
   function automatic logic sel(input int s);
      case (s)
         0: return done;
         1: return kill;
         2: return m_n;
         default: return rxv;
      endcase
   endfunction
   task automatic wt(input int s, input logic v);
      int i = 0;
      while (sel(s) !== v && i < 40) begin
         @(negedge clk);
         i++;
      end
      chk(i < 40, 1'b1, "no answer");
   endtask
   task automatic t_write;
      rv = 1;
      wt(0, 1);
      chk(pv_n, 1'b0, "write strobe");
      chk(d_ad === 32'h0000_1000 && d_cmd === 5'h08, 1'b1, "write cmd word");
      rv = 0;
      wv = 1;
      @(negedge clk);
      chk(pv_n === 1'b0 && d_cmd === 5'h18, 1'b1, "write data word");
      chk(d_ad, 1'b1, "write data bit");
      wv = 0;
      $display("write test done");
   endtask
   task automatic t_kill;
      acc = 0;
      repeat (6) @(negedge clk);
      rv = 1;
      wt(1, 1);
      rv = 0;
      acc = 1;
      repeat (6) @(negedge clk);
      t_write;
      $display("kill test done");
   endtask
   task automatic t_read;
      rd = 1;
      rv = 1;
      wt(0, 1);
      rv = 0;
      wt(2, 1);
      repeat (4) @(negedge clk);
      chk(m_n & pend, 1'b1, "slave held");
      end_of_data_tag = 1;
      @(negedge clk);
      end_of_data_tag = 0;
      wt(3, 1);
      chk(rxc === 5'h18, 1'b1, "eod word");
      chk(rxa === 32'h1234_5678, 1'b1, "eod data");
      wt(2, 0);
      chk(pend, 1'b0, "read cleared");
      rd = 0;
      $display("read test done");
   endtask
   task automatic t_arb;
      int n = 0;
      want = 1;
      wt(2, 1);
      chk(d_oe, 1'b0, "bus released");
      repeat (8) @(negedge clk);
      chk(m_n, 1'b1, "agent keeps bus");
      want = 0;
      while (m_n !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(n >= 2 && n <= 9, 1'b1, "return delay");
      $display("arbitration test done");
   endtask
   task automatic t_reset;
      want = 1;
      wt(2, 1);
      cold_n = 0;
      wt(2, 0);
      chk(d_oe, 1'b1, "drives after reset");
      want = 0;
      cold_n = 1;
      repeat (10) @(negedge clk);
      chk(m_n, 1'b0, "stays master");
      $display("reset test done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 0;
      repeat (5) @(negedge clk);
      t_write;
      t_kill;
      t_read;
      t_arb;
      t_reset;
      summarize;
   end
   initial begin
      #20us;
      n_errors++;
      summarize;
   end
endmodule // system_bus_mastership_arbiter_tb_top
